// >>> inc/vds_consts.svh
// constants for the container-3 to 44 736 kbit/s sink adaptation
// assumes a 250 MHz system clock; included by the rtl only, the package does not include it
// Function
// - recover the 44 736 kbit/s stream, +-20 ppm, from a +-4,6 ppm container
// - compare the accepted label byte against expected code 0000 0100
// - ignore the multiframe indicator byte completely
// - discard fixed stuff and overhead bits without interpreting them
// - control majority 0: opportunity bit is data; majority 1: drop it
// - write extracted data bits into an elastic store on the gapped clock
// - read the store with an even, smoothed clock tracking the far-end rate
// - store deep enough that jitter and +-20 ppm never cause bit errors
// - recover error free within about 1 second after a frequency step
// - when inactive: output all ones and suppress management status
// - detect label mismatch defect from the accepted label
// - signal fail or mismatch: fail output and all ones within 250 us
// - during all ones the client clock runs at 34 368 kHz
// - report mismatch cause only with defect present and no trail fail
`ifndef VDS_CONSTS_SVH
`define VDS_CONSTS_SVH

// ----------------------------------------
// frame layout
// ----------------------------------------
`define VDS_ROW_BYTES 7'd85
`define VDS_ROWS 4'd9
`define VDS_LABEL_ROW 4'd2
`define VDS_CTRL_MAJ 3'd3

// ----------------------------------------
// label handling
// ----------------------------------------
`define VDS_EXPECTED_LABEL 8'h04
`define VDS_EQUIPPED_ANY 8'h01
`define VDS_LABEL_ACCEPT 3'd5

// ----------------------------------------
// rates and times
// ----------------------------------------
`define VDS_CLK_KHZ 64'd250000
`define VDS_CLIENT_KHZ 64'd44736
`define VDS_AIS_KHZ 64'd34368
`define VDS_CLIENT_PPM 20
`define VDS_CONTAINER_PPM_X10 46
`define VDS_AIS_MAX_US 64'd250
`define VDS_AIS_MAX_CYC (`VDS_AIS_MAX_US * `VDS_CLK_KHZ / 64'd1000)
`define VDS_RECOVERY_S 1
`define VDS_NCO_NOM (`VDS_CLIENT_KHZ * 64'h100000000 / `VDS_CLK_KHZ)
`define VDS_NCO_AIS (`VDS_AIS_KHZ * 64'h100000000 / `VDS_CLK_KHZ)
`define VDS_FIFO_DEPTH 16

`endif

// >>> inc/vds_pkg.sv
// types for the container-3 sink adaptation
// assumes vds_consts.svh sits on the include path
package vds_pkg;
   // ----------------------------------------
   // kind of each container bit position
   // ----------------------------------------
   typedef enum logic [1:0]
   {
      vds_data = 2'b00,
      vds_fixed = 2'b01,
      vds_ctrl = 2'b10,
      vds_opp = 2'b11
   } vds_kind_t;
endpackage

// >>> rtl/vds_demapper.sv
// container-3 to 44 736 kbit/s sink adaptation with elastic store
// assumes path pins come from another clock domain and are resynchronised here
`timescale 1ns/10ps
`include "vds_consts.svh"

// ----------------------------------------
// elastic store
// ----------------------------------------
module vds_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = `VDS_FIFO_DEPTH,
   parameter int AW = $clog2(DEPTH)
)(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   // fill level
   output logic [AW:0] level
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp_reg;
   logic [AW-1:0] rp_reg;
   logic [AW:0] cnt_reg;
   logic do_wr;
   logic do_rd;

   assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
   assign out_valid = (cnt_reg != '0);
   assign out_data = mem[rp_reg];
   assign level = cnt_reg;
   assign do_wr = in_valid & in_ready;
   assign do_rd = out_valid & out_ready;

   always_ff @(posedge clk)
   begin
      if (do_wr)
      begin
         mem[wp_reg] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wp_reg <= '0;
         rp_reg <= '0;
         cnt_reg <= '0;
      end
      else
      begin
         if (do_wr)
         begin
            wp_reg <= (wp_reg == AW'(DEPTH - 1)) ? '0 : wp_reg + 1'b1;
         end
         if (do_rd)
         begin
            rp_reg <= (rp_reg == AW'(DEPTH - 1)) ? '0 : rp_reg + 1'b1;
         end
         if (do_wr & ~do_rd)
         begin
            cnt_reg <= cnt_reg + 1'b1;
         end
         else if (do_rd & ~do_wr)
         begin
            cnt_reg <= cnt_reg - 1'b1;
         end
      end
   end
endmodule

// ----------------------------------------
// sink adaptation top
// ----------------------------------------
module vds_demapper #(
   parameter int DEPTH = `VDS_FIFO_DEPTH
)(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // path side
   input wire logic path_payload_data_in,
   input wire logic path_gapped_clock_in,
   input wire logic path_frame_start_in,
   input wire logic trail_signal_fail_in,
   // management
   input wire logic function_activation,
   output logic mismatch_cause_report,
   output logic [7:0] accepted_label_report,
   // client side
   output logic client_data_out,
   output logic client_clock_out,
   output logic server_signal_fail_out
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [31:0] NCO_NOM = 32'(`VDS_NCO_NOM);
   localparam logic [31:0] NCO_AIS = 32'(`VDS_NCO_AIS);

   // position of a container byte/bit in the row (byte 0 is the row's overhead)
   function automatic vds_pkg::vds_kind_t kind_of(input logic [6:0] byt,
                                                  input logic [2:0] bt);
      vds_pkg::vds_kind_t k;
      k = vds_pkg::vds_data;
      unique case (byt)
         7'd0, 7'd1, 7'd2, 7'd30, 7'd58:
            k = vds_pkg::vds_fixed;
         7'd3:
            k = (bt == 3'd2) ? vds_pkg::vds_ctrl :
                (bt < 3'd2) ? vds_pkg::vds_fixed : vds_pkg::vds_data;
         7'd31:
            k = (bt < 3'd2) ? vds_pkg::vds_ctrl : vds_pkg::vds_fixed;
         7'd59:
            k = (bt < 3'd2) ? vds_pkg::vds_ctrl :
                (bt == 3'd7) ? vds_pkg::vds_opp : vds_pkg::vds_fixed;
         default:
            k = vds_pkg::vds_data;
      endcase
      return k;
   endfunction

   // ----------------------------------------
   // pin synchronisers and link clock edge
   // ----------------------------------------
   logic [3:0] sync1_reg;
   logic [3:0] sync2_reg;
   logic ck_last_reg;
   logic ck_rise;
   logic d_in;
   logic fs_in;
   logic tsf;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sync1_reg <= 4'h0;
         sync2_reg <= 4'h0;
         ck_last_reg <= 1'b0;
      end
      else
      begin
         sync1_reg <= {trail_signal_fail_in, path_frame_start_in,
                       path_payload_data_in, path_gapped_clock_in};
         sync2_reg <= sync1_reg;
         ck_last_reg <= sync2_reg[0];
      end
   end

   assign ck_rise = sync2_reg[0] & ~ck_last_reg;
   assign d_in = sync2_reg[1];
   assign fs_in = sync2_reg[2];
   assign tsf = sync2_reg[3];

   // ----------------------------------------
   // frame position counters
   // ----------------------------------------
   logic [2:0] bit_reg;
   logic [6:0] byte_reg;
   logic [3:0] row_reg;
   logic [2:0] cur_bit;
   logic [6:0] cur_byte;
   logic [3:0] cur_row;
   vds_pkg::vds_kind_t cur_kind;

   // frame start marks the first bit of row 0
   assign cur_bit = fs_in ? 3'd0 : bit_reg;
   assign cur_byte = fs_in ? 7'd0 : byte_reg;
   assign cur_row = fs_in ? 4'd0 : row_reg;
   assign cur_kind = kind_of(cur_byte, cur_bit);

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         bit_reg <= 3'd0;
         byte_reg <= 7'd0;
         row_reg <= 4'd0;
      end
      else if (ck_rise)
      begin
         bit_reg <= cur_bit + 3'd1;
         if (cur_bit == 3'd7)
         begin
            if (cur_byte == `VDS_ROW_BYTES - 7'd1)
            begin
               byte_reg <= 7'd0;
               row_reg <= (cur_row == `VDS_ROWS - 4'd1) ? 4'd0 : cur_row + 4'd1;
            end
            else
            begin
               byte_reg <= cur_byte + 7'd1;
               row_reg <= cur_row;
            end
         end
         else
         begin
            byte_reg <= cur_byte;
            row_reg <= cur_row;
         end
      end
   end

   // ----------------------------------------
   // justification control vote
   // ----------------------------------------
   logic [2:0] c_ones_reg;
   logic opp_is_data;
   logic wr_valid;
   logic wr_ready;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         c_ones_reg <= 3'd0;
      end
      else if (ck_rise)
      begin
         if (cur_byte == 7'd0)
         begin
            c_ones_reg <= 3'd0;
         end
         else if (cur_kind == vds_pkg::vds_ctrl && d_in)
         begin
            c_ones_reg <= c_ones_reg + 3'd1;
         end
      end
   end

   assign opp_is_data = (c_ones_reg < `VDS_CTRL_MAJ);
   // fixed stuff, overhead and the whole overhead column never reach the store
   assign wr_valid = ck_rise & ((cur_kind == vds_pkg::vds_data) |
                     ((cur_kind == vds_pkg::vds_opp) & opp_is_data));

   // ----------------------------------------
   // label acceptance and mismatch
   // ----------------------------------------
   logic [6:0] shift_reg;
   logic [7:0] cand_reg;
   logic [2:0] same_reg;
   logic [7:0] acc_reg;
   logic [7:0] label_now;
   logic label_done;
   logic plm;

   assign label_now = {shift_reg, d_in};
   assign label_done = ck_rise & (cur_row == `VDS_LABEL_ROW) &
                       (cur_byte == 7'd0) & (cur_bit == 3'd7);

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         shift_reg <= 7'h00;
      end
      else if (ck_rise)
      begin
         shift_reg <= label_now[6:0];
      end
   end

   // a value is accepted once seen in five frames running
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cand_reg <= `VDS_EXPECTED_LABEL;
         same_reg <= 3'd0;
         acc_reg <= `VDS_EXPECTED_LABEL;
      end
      else if (label_done)
      begin
         if (label_now == cand_reg)
         begin
            if (same_reg == `VDS_LABEL_ACCEPT - 3'd1)
            begin
               acc_reg <= cand_reg;
            end
            else
            begin
               same_reg <= same_reg + 3'd1;
            end
         end
         else
         begin
            cand_reg <= label_now;
            same_reg <= 3'd1;
         end
      end
   end

   // the generic "equipped, non-specific" code is accepted as a match
   assign plm = (acc_reg != `VDS_EXPECTED_LABEL) &
                (acc_reg != `VDS_EQUIPPED_ANY);

   // ----------------------------------------
   // elastic store and smoothed read clock
   // ----------------------------------------
   logic rd_valid;
   logic rd_data;
   logic [AW:0] level;
   logic [31:0] nco_reg;
   logic [32:0] nco_sum;
   logic [31:0] inc;
   logic ais;
   logic tick;

   vds_fifo #(.WIDTH(1), .DEPTH(DEPTH)) u_store (
      .clk(clk),
      .rst_b(rst_b),
      .in_valid(wr_valid),
      .in_ready(wr_ready),
      .in_data(d_in),
      .out_valid(rd_valid),
      .out_ready(tick),
      .out_data(rd_data),
      .level(level)
   );

   assign ais = ~function_activation | tsf | plm;
   // rate scales with fill: nominal at half full, doubled when full, so the
   // reader follows the far-end rate; a full store also forces a read
   assign inc = ais ? NCO_AIS : 32'((NCO_NOM >> 3) * 32'(level));
   assign nco_sum = {1'b0, nco_reg} + {1'b0, inc};
   assign tick = nco_sum[32] | ~wr_ready;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         nco_reg <= 32'h0;
      end
      else
      begin
         nco_reg <= nco_sum[31:0];
      end
   end

   // ----------------------------------------
   // client and management outputs
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         client_clock_out <= 1'b0;
         client_data_out <= 1'b1;
      end
      else
      begin
         client_clock_out <= nco_sum[31];
         if (tick)
         begin
            // underrun reads as ones rather than stale data
            client_data_out <= ais | ~rd_valid | rd_data;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         server_signal_fail_out <= 1'b0;
         mismatch_cause_report <= 1'b0;
         accepted_label_report <= 8'h00;
      end
      else
      begin
         server_signal_fail_out <= tsf | plm;
         mismatch_cause_report <= function_activation & plm & ~tsf;
         accepted_label_report <= function_activation ? acc_reg : 8'h00;
      end
   end
endmodule

// >>> bench/vds_demapper_monitor.sv
// checker of the sink adaptation's port behaviour, bound into vds_demapper
// assumes one clock domain with an asynchronous active low reset
`timescale 1ns/10ps
module vds_demapper_monitor #(
   parameter int DEPTH = 16
)(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // path side
   input wire logic path_payload_data_in,
   input wire logic path_gapped_clock_in,
   input wire logic path_frame_start_in,
   input wire logic trail_signal_fail_in,
   // management
   input wire logic function_activation,
   input wire logic mismatch_cause_report,
   input wire logic [7:0] accepted_label_report,
   // client side
   input wire logic client_data_out,
   input wire logic client_clock_out,
   input wire logic server_signal_fail_out
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   // ----
   // sequences
   // ----
   sequence s_fail_held;
      server_signal_fail_out [*8];
   endsequence
   sequence s_idle_held;
      !function_activation [*8];
   endsequence
   // sixteen samples of fail output, so every step since the last rise ran at the substitute rate
   sequence s_fail_long;
      s_fail_held ##1 s_fail_held;
   endsequence
   // ----
   // helper: clock edges since the last rise of the client clock
   // ----
   logic cco_q;
   logic [3:0] gap_reg;
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cco_q <= 1'b0;
         gap_reg <= 4'h0;
      end
      else
      begin
         cco_q <= client_clock_out;
         if (client_clock_out & ~cco_q)
         begin
            gap_reg <= 4'h1;
         end
         else if (gap_reg != 4'hf)
         begin
            gap_reg <= gap_reg + 4'h1;
         end
      end
   end
   // ----
   // assertions
   // ----
   a_ssf_on_tsf: assert property (
      trail_signal_fail_in [*6] |-> server_signal_fail_out)
      else $error("fail output low under trail fail");
   a_ssf_clears: assert property (
      (!trail_signal_fail_in && accepted_label_report == 8'h04) [*6] |-> !server_signal_fail_out)
      else $error("fail output stuck high");
   // fail output and a falling client clock come from the same cycle's decision
   a_ais_data: assert property (
      s_fail_held ##0 $fell(client_clock_out) |-> client_data_out)
      else $error("zero sent during all ones");
   // slot spacing 7 or 8 cycles gives the substitute clock rate
   a_ais_clock: assert property (
      s_fail_long ##0 $rose(client_clock_out) |-> gap_reg == 4'h7 || gap_reg == 4'h8)
      else $error("substitute clock off rate");
   a_idle_data: assert property (
      s_idle_held ##1 $fell(client_clock_out) |-> client_data_out)
      else $error("zero sent while inactive");
   a_idle_quiet: assert property (
      !function_activation |=> accepted_label_report == 8'h00 && !mismatch_cause_report)
      else $error("status reported while inactive");
   a_cause_no_tsf: assert property (
      trail_signal_fail_in [*6] |-> !mismatch_cause_report)
      else $error("cause reported under trail fail");
   a_cause_ssf: assert property (
      mismatch_cause_report |-> server_signal_fail_out)
      else $error("cause without fail output");
   a_cause_label: assert property (
      mismatch_cause_report |-> accepted_label_report != 8'h04 && accepted_label_report != 8'h01)
      else $error("cause with matching label");
endmodule

bind vds_demapper vds_demapper_monitor #(.DEPTH(DEPTH)) u_monitor (
   .clk(clk), .rst_b(rst_b), .path_payload_data_in(path_payload_data_in),
   .path_gapped_clock_in(path_gapped_clock_in), .path_frame_start_in(path_frame_start_in),
   .trail_signal_fail_in(trail_signal_fail_in), .function_activation(function_activation),
   .mismatch_cause_report(mismatch_cause_report), .accepted_label_report(accepted_label_report),
   .client_data_out(client_data_out), .client_clock_out(client_clock_out),
   .server_signal_fail_out(server_signal_fail_out)
);

// >>> bench/vds_path_source.sv
// model of the container-3 path termination feeding the sink adaptation
// assumes the bench calls send_rows; the link clock stands still between calls
`timescale 1ns/10ps
module vds_path_source #(
   parameter logic [7:0] LABEL = 8'h04
)(
   // link pins
   output logic path_gapped_clock_in,
   output logic path_payload_data_in,
   output logic path_frame_start_in
);
   int pos = 0;
   // set by the bench: rows carry a positive justification
   logic justify = 1'b0;
   initial
   begin
      path_gapped_clock_in = 1'b0;
      path_payload_data_in = 1'b1;
      path_frame_start_in = 1'b0;
   end
   // data zero and stuff one, so a leaking stuff, overhead or dropped-S bit shows;
   // two control bits of five are always wrong to exercise the vote
   function automatic logic row_bit(input int row, input int b, input int p);
      case (b)
         0: return (row == 2) ? LABEL[7-p] : 1'b1;
         1, 2, 30, 58: return 1'b1;
         3: return p < 2 || (p == 2 && !justify);
         31: return p > 1 || justify;
         59: return (p > 1 && p < 7) || (p == 0 && justify) || (p == 1 && !justify) ||
                    (p == 7 && justify);
         default: return 1'b0;
      endcase
   endfunction
   task automatic send_rows(input int n);
      repeat (n * 680)
      begin
         path_frame_start_in = (pos == 0);
         path_payload_data_in = row_bit(pos / 680, (pos % 680) / 8, pos % 8);
         #40 path_gapped_clock_in = 1'b1;
         #40 path_gapped_clock_in = 1'b0;
         pos = (pos + 1) % 6120;
      end
      // released lines show the inverse, never a stale level
      path_payload_data_in = ~path_payload_data_in;
      path_frame_start_in = ~path_frame_start_in;
   endtask
endmodule

// >>> bench/test_vds_demapper.sv
// self-checking bench of the container-3 sink adaptation
// assumes vds_path_source drives the link and the checker is bound in
`timescale 1ns/10ps
module test_vds_demapper;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic trail_signal_fail_in = 1'b0;
   logic function_activation = 1'b1;
   logic gck, pdata, pfs, ck_q;
   logic mismatch_cause_report, client_data_out, client_clock_out, server_signal_fail_out;
   logic [7:0] accepted_label_report;
   int fail_count = 0;
   int compares = 0;
   int zeros = 0;
   int rises = 0;
   int leaks = 0;
   always #2 clk = ~clk;
   vds_demapper #(.DEPTH(16)) DUT (
      .clk(clk), .rst_b(rst_b), .path_payload_data_in(pdata), .path_gapped_clock_in(gck),
      .path_frame_start_in(pfs), .trail_signal_fail_in(trail_signal_fail_in),
      .function_activation(function_activation), .mismatch_cause_report(mismatch_cause_report),
      .accepted_label_report(accepted_label_report), .client_data_out(client_data_out),
      .client_clock_out(client_clock_out), .server_signal_fail_out(server_signal_fail_out)
   );
   vds_path_source src (
      .path_gapped_clock_in(gck), .path_payload_data_in(pdata), .path_frame_start_in(pfs)
   );
   always @(posedge clk)
   begin
      if (client_data_out === 1'b0) zeros++;
      if (client_data_out === 1'b1 && zeros != 0) leaks++;
      if (client_clock_out === 1'b1 && ck_q === 1'b0) rises++;
      ck_q = client_clock_out;
   end
   // ----
   // tasks
   // ----
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp)
      begin
         $display("mismatch %s expected %h seen %h", what, exp, got);
         fail_count++;
      end
   endtask
   task automatic stop_test();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic drive(input logic act, input logic tsf, input int settle);
      @(posedge clk);
      #1;
      function_activation = act;
      trail_signal_fail_in = tsf;
      repeat (settle) @(posedge clk);
      #1;
      zeros = 0;
      rises = 0;
      leaks = 0;
   endtask
   // data is all zero, so once a zero is out any one is a leaked stuff bit
   task automatic stream_check(input string what, input logic want);
      src.send_rows(1);
      check(what, {15'h0, want}, {15'h0, zeros != 0});
      check({what, " leak"}, 16'h0000, 16'(leaks));
   endtask
   // ----
   // tests
   // ----
   initial
   begin
      repeat (12) @(posedge clk);
      #1 rst_b = 1'b1;
      drive(1'b1, 1'b0, 4);
      check("label", 16'h0004, {8'h00, accepted_label_report});
      check("cause", 16'h0000, {15'h0, mismatch_cause_report});
      check("fail out", 16'h0000, {15'h0, server_signal_fail_out});
      src.justify = 1'b1;
      stream_check("data zeros", 1'b1);
      $display("test normal done");
      drive(1'b0, 1'b0, 100);
      check("label", 16'h0000, {8'h00, accepted_label_report});
      check("cause", 16'h0000, {15'h0, mismatch_cause_report});
      stream_check("inactive zeros", 1'b0);
      $display("test inactive done");
      drive(1'b1, 1'b1, 100);
      check("fail out", 16'h0001, {15'h0, server_signal_fail_out});
      check("cause", 16'h0000, {15'h0, mismatch_cause_report});
      repeat (2000) @(posedge clk);
      check("ais rate", 16'h0001, {15'h0, rises == 274 || rises == 275});
      stream_check("ais zeros", 1'b0);
      $display("test trail fail done");
      drive(1'b1, 1'b0, 8);
      check("fail out", 16'h0000, {15'h0, server_signal_fail_out});
      stream_check("restored zeros", 1'b1);
      $display("test restore done");
      @(posedge clk);
      #1 rst_b = 1'b0;
      repeat (4) @(posedge clk);
      #1 rst_b = 1'b1;
      drive(1'b1, 1'b0, 2);
      check("reset data", 16'h0001, {15'h0, client_data_out});
      check("reset label", 16'h0004, {8'h00, accepted_label_report});
      check("reset fail out", 16'h0000, {15'h0, server_signal_fail_out});
      $display("test reset done");
      stop_test();
   end
   initial
   begin
      #400000;
      fail_count++;
      $display("watchdog expired");
      stop_test();
   end
endmodule
